// *** dv/sgm_far_side.sv ***
// Board-side model of the five pads
`timescale 1ns/1ps
module sgm_far_side (
  input wire logic [4:0] pad_out_i,
  input wire logic [4:0] pad_oe_n_i,
  input wire logic [4:0] board_lvl_i,
  output logic [4:0] pad_in_o
);
  // Device drive wins over the board level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pad_in_o[i] = pad_oe_n_i[i] ? board_lvl_i[i] : pad_out_i[i];
    end
  end
endmodule : sgm_far_side

// *** dv/tb_top.sv ***
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; int p; logic [2:0] e;} sgm_row_type;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic wr_i = 0, rd_i = 0, remote_val_i = 0, link_up_i = 0;
  logic [4:0] board_lvl = 0, pad_in, pad_out_o, pad_oe_n_o, func_sel_o, sw_in_o;
  int n_mismatch = 0;
  int num_checks = 0;
  sgm_row_type rows [13];
  always #5 clk_i = ~clk_i;
  sgm_gpio_cfg dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .remote_val_i(remote_val_i), .link_up_i(link_up_i),
    .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .func_sel_o(func_sel_o),
    .sw_in_o(sw_in_o));
  sgm_far_side far (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .board_lvl_i(board_lvl),
    .pad_in_o(pad_in));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", e, rdata_o);
  endtask : rd
  // Pads settle two edges after the write task returns; two more as margin
  task automatic pin(input int p, input logic [2:0] e);
    repeat (4) @(posedge clk_i);
    #1;
    chk("oe_n", {7'h00, e[1]}, {7'h00, pad_oe_n_o[p]});
    chk("func", {7'h00, e[0]}, {7'h00, func_sel_o[p]});
    if (!e[1]) chk("out", {7'h00, e[2]}, {7'h00, pad_out_o[p]});
  endtask : pin
  task automatic lnk(input logic r, input logic l);
    @(posedge clk_i);
    remote_val_i <= r;
    link_up_i <= l;
  endtask : lnk
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rows = '{'{8'h0f, 8'h04, 0, 3'b011}, '{8'h0f, 8'h06, 0, 3'b010}, '{8'h0f, 8'h02, 0, 3'b010},
      '{8'h0f, 8'hf9, 0, 3'b100}, '{8'h0f, 8'h01, 0, 3'b000}, '{8'h0f, 8'h0b, 0, 3'b010},
      '{8'h10, 8'h09, 1, 3'b100}, '{8'h10, 8'hc2, 1, 3'b010}, '{8'h10, 8'h90, 2, 3'b100},
      '{8'h11, 8'h4d, 3, 3'b100}, '{8'h11, 8'h30, 4, 3'b010}, '{8'h11, 8'h88, 4, 3'b011},
      '{8'h11, 8'h01, 3, 3'b000}};
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("oe_n rst", 8'h1f, {3'h0, pad_oe_n_o});
    chk("func rst", 8'h1f, {3'h0, func_sel_o});
    for (int i = 0; i < 3; i++) rd(8'h0f + i[7:0], 8'h00);
    rd(8'h12, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      pin(rows[i].p, rows[i].e);
      rd(rows[i].a, rows[i].d & (rows[i].a == 8'h0f ? 8'h0f : 8'hbb));
    end
    $display("table test done");
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h00);
    board_lvl <= 5'h1f;
    wr(8'h0f, 8'h03);
    wr(8'h10, 8'h03);
    pin(1, 3'b010);
    chk("sw_in hi", 8'h03, {3'h0, sw_in_o & 5'h03});
    board_lvl <= 5'h00;
    pin(0, 3'b010);
    chk("sw_in lo", 8'h00, {3'h0, sw_in_o & 5'h03});
    board_lvl <= 5'h1f;
    wr(8'h11, 8'h33);
    pin(4, 3'b010);
    chk("sw_in 78", 8'h18, {3'h0, sw_in_o & 5'h1c});
    $display("input test done");
    lnk(1'b1, 1'b1);
    wr(8'h0f, 8'h05);
    pin(0, 3'b100);
    lnk(1'b0, 1'b0);
    pin(0, 3'b100);
    lnk(1'b0, 1'b1);
    wr(8'h0f, 8'h0d);
    pin(0, 3'b000);
    lnk(1'b1, 1'b0);
    pin(0, 3'b000);
    lnk(1'b1, 1'b1);
    wr(8'h0f, 8'h07);
    pin(0, 3'b100);
    lnk(1'b1, 1'b0);
    pin(0, 3'b000);
    wr(8'h0f, 8'h0f);
    pin(0, 3'b100);
    $display("remote test done");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    #1;
    chk("oe_n rst2", 8'h1f, {3'h0, pad_oe_n_o});
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'h0f, 8'h00);
    rd(8'h10, 8'h00);
    $display("second reset test done");
    wrap_up();
  end
endmodule : tb_top

// *** verilog/sgm_gpio_cfg.sv ***
// Top: register file and pin control for five configurable pins
//
// Functional notes
// - Pin three mode with low bits 00 is functional input and with low bits 10 is high impedance.
// - Pin three mode 001 is a software output and 011 a software-readable input.
// - Pin three mode 101 drives the pin from the remote value.
// - In mode 101 the last remote level is kept on link loss.
// - Mode 111 follows the remote value, and on link loss drives the local bit.
// - Pin three's local bit shows in software output mode and in mode 111 on link loss.
// - All three registers reset to zero; a written 1 drives the pin high.
// - Pins five to eight: mode 00 is functional input and 10 high impedance.
// - Pins five to eight: 01 is software output, 11 software input, no remote modes.
// - Pins five to eight drive their value bit in output mode.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "sgm_regs.svh"
module sgm_gpio_cfg (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic remote_val_i,
  input wire logic link_up_i,
  input wire logic [4:0] pad_in_i,
  output logic [4:0] pad_out_o,
  output logic [4:0] pad_oe_n_o,
  output logic [4:0] func_sel_o,
  output logic [4:0] sw_in_o
);
  import sgm_pkg::*;

  logic [7:0] p3_r;
  logic [7:0] p56_r;
  logic [7:0] p78_r;
  logic [7:0] rd_nxt;
  sgm_pin_drv_type drv [5];
  logic [4:0] swin;
  logic [1:0] lo_mode [4];
  logic [3:0] lo_val;

  ////////////////////////////////////////////////////////////////
  // Register writes
  // Zero reset and stored value bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p3_r <= `SGM_RESET_VAL;
      p56_r <= `SGM_RESET_VAL;
      p78_r <= `SGM_RESET_VAL;
    end else if (wr_i) begin
      case (addr_i)
        `SGM_OFF_PIN_THREE: p3_r <= wdata_i & `SGM_P3_MASK;
        `SGM_OFF_PINS_FIVE_SIX: p56_r <= wdata_i & `SGM_PAIR_MASK;
        `SGM_OFF_PINS_SEVEN_EIGHT: p78_r <= wdata_i & `SGM_PAIR_MASK;
        default: p3_r <= p3_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read port; only the three config words read back, other offsets read zero
  always_comb begin
    case (addr_i)
      `SGM_OFF_PIN_THREE: rd_nxt = p3_r;
      `SGM_OFF_PINS_FIVE_SIX: rd_nxt = p56_r;
      `SGM_OFF_PINS_SEVEN_EIGHT: rd_nxt = p78_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin controllers
  sgm_pin_three u_pin_three (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .mode_i(p3_r[2:0]),
    .val_i(p3_r[`SGM_LO_VAL_BIT]),
    .pad_i(pad_in_i[0]),
    .remote_val_i(remote_val_i),
    .link_up_i(link_up_i),
    .drv_o(drv[0]),
    .sw_in_o(swin[0])
  );

  assign lo_mode[0] = p56_r[`SGM_LO_MODE_LSB +: 2];
  assign lo_mode[1] = p56_r[`SGM_HI_MODE_LSB +: 2];
  assign lo_mode[2] = p78_r[`SGM_LO_MODE_LSB +: 2];
  assign lo_mode[3] = p78_r[`SGM_HI_MODE_LSB +: 2];
  assign lo_val = {p78_r[`SGM_HI_VAL_BIT], p78_r[`SGM_LO_VAL_BIT], p56_r[`SGM_HI_VAL_BIT], p56_r[`SGM_LO_VAL_BIT]};

  for (genvar g = 0; g < 4; g++) begin : g_pin
    sgm_pin_ctrl u_pin (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .mode_i(lo_mode[g]),
      .val_i(lo_val[g]),
      .pad_i(pad_in_i[g+1]),
      .drv_o(drv[g+1]),
      .sw_in_o(swin[g+1])
    );
  end

  // Outputs re-registered so all top outputs come from flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_out_o <= 5'h00;
      pad_oe_n_o <= 5'h1f;
      func_sel_o <= 5'h1f;
      sw_in_o <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        pad_out_o[i] <= drv[i].out;
        pad_oe_n_o[i] <= drv[i].oe_n;
        func_sel_o[i] <= drv[i].func_sel;
      end
      sw_in_o <= swin;
    end
  end

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_i |=> (p3_r[7:4] == 4'h0 && p56_r[6] == 1'b0 && p56_r[2] == 1'b0 && p78_r[6] == 1'b0 && p78_r[2] == 1'b0))
    else $error("reserved bit set");
  wr_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_i && addr_i == `SGM_OFF_PINS_FIVE_SIX && wdata_i == 8'h09) |=> ##2 (pad_out_o[1] && !pad_oe_n_o[1]))
    else $error("written one did not drive pin high");
  rd_back_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == `SGM_OFF_PIN_THREE) |=> (rdata_o == $past(p3_r)))
    else $error("readback mismatch");
  wr_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i) wr_i ##1 rd_i);
endmodule : sgm_gpio_cfg

// *** verilog/sgm_pin_ctrl.sv ***
// One local-only pin: decodes a 2-bit mode and drives the pad
`timescale 1ns/1ps
module sgm_pin_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic val_i,
  input wire logic pad_i,
  output sgm_pkg::sgm_pin_drv_type drv_o,
  output logic sw_in_o
);
  import sgm_pkg::*;

  sgm_pin_drv_type drv_nxt;

  always_comb begin
    drv_nxt = '{out: 1'b0, oe_n: 1'b1, func_sel: 1'b0};
    case (mode_i)
      2'h0: drv_nxt.func_sel = 1'b1;
      2'h1: begin
        drv_nxt.out = val_i;
        drv_nxt.oe_n = 1'b0;
      end
      2'h2: drv_nxt.oe_n = 1'b1;
      2'h3: drv_nxt.oe_n = 1'b1;
      default: drv_nxt.oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drv_o <= '{out: 1'b0, oe_n: 1'b1, func_sel: 1'b1};
      sw_in_o <= 1'b0;
    end else begin
      drv_o <= drv_nxt;
      sw_in_o <= (mode_i == 2'h3) ? pad_i : 1'b0;
    end
  end

  mode_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 2'h1) |=> (!drv_o.oe_n && drv_o.out == $past(val_i)))
    else $error("pin not driving local value in output mode");
  mode_hiz_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i[0] == 1'b0) |=> (drv_o.oe_n && drv_o.func_sel == !$past(mode_i[1])))
    else $error("pin driven in input or high-impedance mode");
endmodule : sgm_pin_ctrl

// *** verilog/sgm_pin_three.sv ***
// Pin three: 3-bit mode with remote hold and remote default behaviour
`timescale 1ns/1ps
module sgm_pin_three (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] mode_i,
  input wire logic val_i,
  input wire logic pad_i,
  input wire logic remote_val_i,
  input wire logic link_up_i,
  output sgm_pkg::sgm_pin_drv_type drv_o,
  output logic sw_in_o
);
  import sgm_pkg::*;

  logic held_r;
  sgm_pin_drv_type drv_nxt;

  // Track remote level while link up
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      held_r <= 1'b0;
    end else if (link_up_i) begin
      held_r <= remote_val_i;
    end
  end

  always_comb begin
    drv_nxt = '{out: 1'b0, oe_n: 1'b1, func_sel: 1'b0};
    case (mode_i)
      // Low bits 00 select functional input
      3'h0, 3'h4: drv_nxt.func_sel = 1'b1;
      3'h2, 3'h6: drv_nxt.oe_n = 1'b1;
      3'h1: begin
        drv_nxt.out = val_i;
        drv_nxt.oe_n = 1'b0;
      end
      3'h3: drv_nxt.oe_n = 1'b1;
      // Remote value, held on link loss
      3'h5: begin
        drv_nxt.out = link_up_i ? remote_val_i : held_r;
        drv_nxt.oe_n = 1'b0;
      end
      // Remote value, local bit on link loss
      3'h7: begin
        drv_nxt.out = link_up_i ? remote_val_i : val_i;
        drv_nxt.oe_n = 1'b0;
      end
      default: drv_nxt.oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drv_o <= '{out: 1'b0, oe_n: 1'b1, func_sel: 1'b1};
      sw_in_o <= 1'b0;
    end else begin
      drv_o <= drv_nxt;
      sw_in_o <= (mode_i == 3'h3) ? pad_i : 1'b0;
    end
  end

  remote_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h5 && !link_up_i) |=> (drv_o.out == $past(held_r) && !drv_o.oe_n))
    else $error("remote hold did not keep last level");
  hold_first_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h5 && !link_up_i && $past(link_up_i)) |=> (drv_o.out == $past(remote_val_i, 2)))
    else $error("remote hold lost last received level");
  remote_dflt_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h7 && !link_up_i) |=> (drv_o.out == $past(val_i)))
    else $error("remote default did not use local bit");
  remote_live_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i[0] && mode_i[2] && link_up_i) |=> (drv_o.out == $past(remote_val_i)))
    else $error("remote mode not following remote value");
  func_in_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i[1:0] == 2'h0) |=> (drv_o.func_sel && drv_o.oe_n))
    else $error("functional input not selected");
  local_out_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h1) |=> (!drv_o.oe_n && drv_o.out == $past(val_i)))
    else $error("local value not on pin");
  hold_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h5 && link_up_i) ##1 (mode_i == 3'h5 && !link_up_i));
  dflt_cov: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_i == 3'h7 && link_up_i) ##1 (mode_i == 3'h7 && !link_up_i));
endmodule : sgm_pin_three

// *** verilog/sgm_pkg.sv ***
// Types shared by the pin configuration block
package sgm_pkg;
  typedef enum logic [1:0] {
    SGM_FUNC_IN,
    SGM_SW_OUT,
    SGM_HIGH_Z,
    SGM_SW_IN
  } sgm_pin_mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sgm_bus_req_type;

  // Three-signal pin view; oe_n low while driving
  typedef struct packed {
    logic out;
    logic oe_n;
    logic func_sel;
  } sgm_pin_drv_type;
endpackage : sgm_pkg

// *** verilog/sgm_regs.svh ***
// Register offsets, field positions, reset values for the pin configuration block
`ifndef SGM_REGS_SVH
`define SGM_REGS_SVH
`define SGM_ADDR_W 8
`define SGM_OFF_PIN_THREE 8'h0f
`define SGM_OFF_PINS_FIVE_SIX 8'h10
`define SGM_OFF_PINS_SEVEN_EIGHT 8'h11
`define SGM_RESET_VAL 8'h00
`define SGM_P3_MASK 8'h0f
`define SGM_PAIR_MASK 8'hbb
`define SGM_LO_MODE_LSB 0
`define SGM_LO_VAL_BIT 3
`define SGM_HI_MODE_LSB 4
`define SGM_HI_VAL_BIT 7
`endif
